// ### src/bus_cycle_unit.sv
// Two-state bus cycles to on-chip memory and the peripheral registers
`timescale 1ns/1ns
module bus_cycle_unit import cpu_pkg::*; #(
    parameter int MEM_WORDS = MEM_WORDS_DEF,
    parameter logic [7:0] HV_MASK = HV_MASK_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic state_en,
    bus_if.slave bus,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    localparam int IDX_W = $clog2(MEM_WORDS);

    logic [15:0] mem [MEM_WORDS];
    logic busy_r, done_r;
    logic [15:0] rdata_r;
    logic [7:0] load_r, count_r, data_r, dir_r;
    logic [7:0] io_rd, port_rd;
    logic [IDX_W-1:0] idx;
    logic fin;
    area_t area;

    assign area = area_of(bus.addr);
    assign idx = bus.addr[IDX_W:1];
    assign fin = state_en && busy_r;
    assign bus.done = done_r;
    assign bus.rdata = rdata_r;

    // ==================================================================
    // Cycle timing: accept at end of T1, complete at end of T2
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (fin) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end else if (state_en && bus.req && !done_r) begin
                busy_r <= 1'b1;
            end
        end
    end

    // Port read: HV pins and std inputs show the pin, std outputs the latch
    assign port_rd = (pin_in & HV_MASK) |
        (~HV_MASK & ((dir_r & data_r) | (~dir_r & pin_in)));

    // Byte read mux for the peripheral area
    always_comb begin
        case (bus.addr)
            TIMER_ADDR: io_rd = count_r;
            PORT_DATA_ADDR: io_rd = port_rd;
            default: io_rd = 8'h00;
        endcase
    end

    // ==================================================================
    // Read data, captured at the completing edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else if (fin && !bus.we) begin
            case (area)
                AREA_MEM: begin
                    if (bus.word) rdata_r <= mem[idx];
                    else if (bus.addr[0]) rdata_r <= {8'h00, mem[idx][7:0]};
                    else rdata_r <= {8'h00, mem[idx][15:8]};
                end
                // Lower half has no source, returns zero
                AREA_IO: rdata_r <= bus.word ? {io_rd, 8'h00}
                                             : {8'h00, io_rd};
                default: rdata_r <= 16'h0000;
            endcase
        end
    end

    // On-chip memory writes; byte lanes are big-endian
    always_ff @(posedge core_clk) begin
        if (fin && bus.we && area == AREA_MEM) begin
            if (bus.word) mem[idx] <= bus.wdata;
            else if (bus.addr[0]) mem[idx][7:0] <= bus.wdata[7:0];
            else mem[idx][15:8] <= bus.wdata[7:0];
        end
    end

    // ==================================================================
    // Peripheral writes; a word only delivers its upper byte
    always_ff @(posedge core_clk) begin
        if (rst) begin
            load_r <= TIMER_LOAD_RST;
            data_r <= PORT_RST;
            dir_r <= PORT_RST;
        end else if (fin && bus.we && area == AREA_IO) begin
            case (bus.addr)
                TIMER_ADDR: load_r <= bus.word ? bus.wdata[15:8]
                                               : bus.wdata[7:0];
                PORT_DATA_ADDR: data_r <= bus.word ? bus.wdata[15:8]
                                                   : bus.wdata[7:0];
                PORT_DIR_ADDR: dir_r <= bus.word ? bus.wdata[15:8]
                                                 : bus.wdata[7:0];
                default: ; // Unmapped writes are dropped
            endcase
        end
    end

    // Counter runs on the system clock regardless of bus activity
    always_ff @(posedge core_clk) begin
        if (rst) count_r <= TIMER_LOAD_RST;
        else if (count_r == 8'h00) count_r <= load_r;
        else count_r <= count_r - 8'h01;
    end

    // HV pins drive high only while their bit is 1, else driver off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
        end else begin
            pin_out <= HV_MASK | (data_r & ~HV_MASK);
            pin_oe <= (data_r & HV_MASK) | (dir_r & ~HV_MASK);
        end
    end

endmodule : bus_cycle_unit

// ### src/bus_if.sv
// Internal bus between the sequencer and the bus cycle unit
`timescale 1ns/1ns
interface bus_if;
    logic req;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    modport master(output req, we, word, addr, wdata, input rdata, done);
    modport slave(input req, we, word, addr, wdata, output rdata, done);
endinterface : bus_if

// ### src/cpu_bus_and_block_move.sv
// Execution sequencer: block move, bit ops, accesses and interrupt save
`timescale 1ns/1ns
module cpu_bus_and_block_move import cpu_pkg::*; #(
    parameter int SUB_DIV = SUB_DIV_DEF,
    parameter int MEM_WORDS = MEM_WORDS_DEF,
    parameter logic [7:0] HV_MASK = HV_MASK_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire sys_mode_t mode_sel,
    input wire logic cmd_valid,
    input wire cmd_t cmd_op,
    input wire bit_op_t cmd_bit_op,
    input wire logic [2:0] cmd_bit_idx,
    input wire gpr_sel_t cmd_gpr,
    input wire logic cmd_word,
    input wire logic [15:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] ccr_in,
    input wire logic irq_req,
    input wire logic [7:0] pin_in,
    output logic cmd_ready,
    output logic cmd_done,
    output logic irq_ack,
    output logic [15:0] rd_data,
    output core_state_t core_state,
    output logic [7:0] count_out,
    output logic [15:0] source_out,
    output logic [15:0] dest_out,
    output logic [15:0] stack_out,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);

    // ==================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000, SQ_ACCESS = 3'b001, SQ_RMW_READ = 3'b010,
        SQ_RMW_WRITE = 3'b011, SQ_MOVE_READ = 3'b100,
        SQ_MOVE_WRITE = 3'b101, SQ_PUSH_PC = 3'b110, SQ_PUSH_CCR = 3'b111
    } seq_t;

    localparam int DIV_W = $clog2(SUB_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SUB_DIV - 1);

    bus_if bus ();

    seq_t seq_r, seq_nxt;
    logic [7:0] byte_count_reg;
    logic [15:0] source_pointer_reg, dest_pointer_reg, stack_pointer_reg;
    logic [DIV_W-1:0] sub_cnt_r;
    logic sub_tick_r, state_en, exec_mode, accept, irq_take, bus_done;
    logic req_r, we_r, word_r;
    logic [15:0] addr_r, wdata_r;
    bit_op_t bit_op_r;
    logic [2:0] bit_idx_r;
    logic carry_r, is_read_r;

    assign bus.req = req_r;
    assign bus.we = we_r;
    assign bus.word = word_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
    assign bus_done = bus.done;

    assign count_out = byte_count_reg;
    assign source_out = source_pointer_reg;
    assign dest_out = dest_pointer_reg;
    assign stack_out = stack_pointer_reg;

    // ==================================================================
    // State timing: one state per system clock, or per subclock tick
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sub_cnt_r <= '0;
            sub_tick_r <= 1'b0;
        end else begin
            sub_tick_r <= (sub_cnt_r == DIV_LAST);
            sub_cnt_r <= (sub_cnt_r == DIV_LAST) ? '0
                                                  : sub_cnt_r + 1'b1;
        end
    end

    // Halt modes freeze the state enable, so no bus cycle can start
    always_comb begin
        case (mode_sel)
            MODE_ACTIVE: state_en = 1'b1;
            MODE_SUBACTIVE: state_en = sub_tick_r;
            default: state_en = 1'b0;
        endcase
    end

    assign exec_mode = (mode_sel == MODE_ACTIVE) ||
                       (mode_sel == MODE_SUBACTIVE);
    assign accept = cmd_valid && cmd_ready;
    // Interrupt waits for the present instruction to finish
    assign irq_take = (seq_r == SQ_IDLE) && irq_req && exec_mode && !accept;

    // ==================================================================
    // Next sequencer state
    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            SQ_IDLE: begin
                if (accept) begin
                    case (cmd_op)
                        CMD_READ, CMD_WRITE: seq_nxt = SQ_ACCESS;
                        CMD_BIT: seq_nxt = SQ_RMW_READ;
                        CMD_BLOCK_MOVE: // Zero count: nothing moved
                            seq_nxt = (byte_count_reg != 8'h00)
                                ? SQ_MOVE_READ : SQ_IDLE;
                        default: seq_nxt = SQ_IDLE;
                    endcase
                end else if (irq_take) begin
                    seq_nxt = SQ_PUSH_PC;
                end
            end
            SQ_ACCESS: if (bus_done) seq_nxt = SQ_IDLE;
            SQ_RMW_READ: if (bus_done) seq_nxt = SQ_RMW_WRITE;
            SQ_RMW_WRITE: if (bus_done) seq_nxt = SQ_IDLE;
            SQ_MOVE_READ: if (bus_done) seq_nxt = SQ_MOVE_WRITE;
            SQ_MOVE_WRITE: begin
                if (bus_done)
                    seq_nxt = (byte_count_reg == 8'h01)
                        ? SQ_IDLE : SQ_MOVE_READ;
            end
            SQ_PUSH_PC: if (bus_done) seq_nxt = SQ_PUSH_CCR;
            SQ_PUSH_CCR: if (bus_done) seq_nxt = SQ_IDLE;
            default: seq_nxt = SQ_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) seq_r <= SQ_IDLE;
        else seq_r <= seq_nxt;
    end

    // ==================================================================
    // Latched command fields for the later bus cycles of a command
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bit_op_r <= BOP_SET;
            bit_idx_r <= 3'b000;
            carry_r <= 1'b0;
            is_read_r <= 1'b0;
        end else if (accept) begin
            bit_op_r <= cmd_bit_op;
            bit_idx_r <= cmd_bit_idx;
            carry_r <= ccr_in[0];
            is_read_r <= (cmd_op == CMD_READ);
        end
    end

    // ==================================================================
    // Bus request launch; a new cycle is set up when one ends unless the sequencer goes idle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_r <= 1'b0;
            we_r <= 1'b0;
            word_r <= 1'b0;
            addr_r <= 16'h0000;
            wdata_r <= 16'h0000;
        end else if (accept || irq_take || bus_done) begin
            req_r <= (seq_nxt != SQ_IDLE);
            case (seq_nxt)
                SQ_ACCESS: begin
                    we_r <= (cmd_op == CMD_WRITE);
                    word_r <= cmd_word;
                    addr_r <= cmd_addr;
                    wdata_r <= cmd_wdata;
                end
                SQ_RMW_READ: begin
                    we_r <= 1'b0;
                    word_r <= 1'b0;
                    addr_r <= cmd_addr;
                end
                SQ_RMW_WRITE: begin
                    we_r <= 1'b1; // Whole byte written back
                    wdata_r <= {8'h00, bit_modify(bus.rdata[7:0], bit_op_r,
                                                  bit_idx_r, carry_r)};
                end
                SQ_MOVE_READ: begin
                    we_r <= 1'b0;
                    word_r <= 1'b0;
                    addr_r <= source_pointer_reg;
                end
                SQ_MOVE_WRITE: begin
                    we_r <= 1'b1;
                    addr_r <= dest_pointer_reg;
                    wdata_r <= {8'h00, bus.rdata[7:0]};
                end
                SQ_PUSH_PC: begin
                    we_r <= 1'b1;
                    word_r <= 1'b1;
                    addr_r <= stack_pointer_reg - PUSH_STEP;
                    wdata_r <= pc_in;
                end
                SQ_PUSH_CCR: begin
                    addr_r <= stack_pointer_reg - PUSH_STEP - PUSH_STEP;
                    wdata_r <= {ccr_in, ccr_in};
                end
                default: we_r <= 1'b0;
            endcase
        end
    end

    // ==================================================================
    // Working registers; pointers step after each moved byte
    always_ff @(posedge core_clk) begin
        if (rst) begin
            byte_count_reg <= 8'h00;
            source_pointer_reg <= 16'h0000;
            dest_pointer_reg <= 16'h0000;
            stack_pointer_reg <= 16'h0000;
        end else if (accept && cmd_op == CMD_LOAD_GPR) begin
            case (cmd_gpr)
                GPR_COUNT: byte_count_reg <= cmd_wdata[7:0];
                GPR_SOURCE: source_pointer_reg <= cmd_wdata;
                GPR_DEST: dest_pointer_reg <= cmd_wdata;
                default: stack_pointer_reg <= cmd_wdata;
            endcase
        end else if (bus_done) begin
            case (seq_r)
                SQ_MOVE_READ:
                    source_pointer_reg <= source_pointer_reg + 16'h0001;
                SQ_MOVE_WRITE: begin
                    // Destination wrap is left to software
                    dest_pointer_reg <= dest_pointer_reg + 16'h0001;
                    byte_count_reg <= byte_count_reg - 8'h01;
                end
                SQ_PUSH_PC, SQ_PUSH_CCR:
                    stack_pointer_reg <= stack_pointer_reg - PUSH_STEP;
                default: ;
            endcase
        end
    end

    // ==================================================================
    // Handshake and result outputs, all registered
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_ready <= 1'b0;
            cmd_done <= 1'b0;
            irq_ack <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            // Ready drops while an interrupt is pending so it goes first
            cmd_ready <= (seq_nxt == SQ_IDLE) && exec_mode && !irq_req;
            // Completion frees the sequencer at once for the next one
            cmd_done <= (accept && seq_nxt == SQ_IDLE) ||
                (bus_done && seq_nxt == SQ_IDLE &&
                 seq_r != SQ_PUSH_CCR);
            irq_ack <= bus_done && seq_r == SQ_PUSH_CCR;
            if (bus_done && seq_r == SQ_ACCESS && is_read_r)
                rd_data <= bus.rdata;
        end
    end

    // Exception handling is transient; halt follows the mode input
    always_ff @(posedge core_clk) begin
        if (rst) core_state <= CS_EXEC;
        else if (seq_nxt == SQ_PUSH_PC || seq_nxt == SQ_PUSH_CCR)
            core_state <= CS_EXCEPT;
        else if (!exec_mode) core_state <= CS_HALT;
        else core_state <= CS_EXEC;
    end

    // ==================================================================
    // Bus cycles, memory and the peripheral registers
    bus_cycle_unit #(
        .MEM_WORDS(MEM_WORDS),
        .HV_MASK(HV_MASK)
    ) u_bus (
        .core_clk(core_clk),
        .rst(rst),
        .state_en(state_en),
        .bus(bus.slave),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

endmodule : cpu_bus_and_block_move

// ### src/cpu_pkg.sv
// Shared constants, types and helpers for the bus and block-move core
package cpu_pkg;

    // ==================================================================
    // Address map and bus widths
    localparam int ADDR_W = 16;
    localparam int MEM_DW = 16;
    localparam int PER_DW = 8;
    localparam logic [15:0] MEM_TOP = 16'hEFFF;
    localparam logic [15:0] IO_BASE = 16'hFF80;
    localparam logic [15:0] TIMER_ADDR = 16'hFFC3;
    localparam logic [15:0] PORT_DATA_ADDR = 16'hFFD1;
    localparam logic [15:0] PORT_DIR_ADDR = 16'hFFE1;
    localparam logic [15:0] PUSH_STEP = 16'h0002;

    // ==================================================================
    // Reset values and timing
    localparam logic [7:0] TIMER_LOAD_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [7:0] HV_MASK_DEF = 8'hF0;
    localparam int SUB_DIV_DEF = 8;
    localparam int MEM_WORDS_DEF = 2048;

    // ==================================================================
    // Enumerations
    typedef enum logic [1:0] {
        AREA_MEM = 2'b00, AREA_IO = 2'b01, AREA_EMPTY = 2'b10
    } area_t;
    typedef enum logic [2:0] {
        CMD_NOP = 3'b000, CMD_LOAD_GPR = 3'b001, CMD_READ = 3'b010,
        CMD_WRITE = 3'b011, CMD_BIT = 3'b100, CMD_BLOCK_MOVE = 3'b101
    } cmd_t;
    typedef enum logic [2:0] {
        BOP_SET = 3'b000, BOP_CLEAR = 3'b001, BOP_INVERT = 3'b010,
        BOP_STORE = 3'b011, BOP_STORE_INV = 3'b100
    } bit_op_t;
    typedef enum logic [1:0] {
        GPR_COUNT = 2'b00, GPR_SOURCE = 2'b01, GPR_DEST = 2'b10,
        GPR_STACK = 2'b11
    } gpr_sel_t;
    typedef enum logic [1:0] {
        CS_EXEC = 2'b00, CS_HALT = 2'b01, CS_EXCEPT = 2'b10
    } core_state_t;
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b000, MODE_SUBACTIVE = 3'b001, MODE_SLEEP = 3'b010,
        MODE_STANDBY = 3'b011, MODE_WATCH = 3'b100
    } sys_mode_t;

    // ==================================================================
    // Helpers
    function automatic area_t area_of(input logic [15:0] a);
        if (a <= MEM_TOP) return AREA_MEM;
        else if (a >= IO_BASE) return AREA_IO;
        else return AREA_EMPTY;
    endfunction : area_of

    function automatic logic [7:0] bit_modify(input logic [7:0] d,
            input bit_op_t op, input logic [2:0] idx, input logic c);
        logic [7:0] m;
        m = 8'h01 << idx;
        case (op)
            BOP_SET: return d | m;
            BOP_CLEAR: return d & ~m;
            BOP_INVERT: return d ^ m;
            BOP_STORE: return c ? (d | m) : (d & ~m);
            BOP_STORE_INV: return c ? (d & ~m) : (d | m);
            default: return d;
        endcase
    endfunction : bit_modify

endpackage : cpu_pkg

// ### tb/cpu_bus_and_block_move_bench.sv
// Self-checking bench for the bus and block-move core
`timescale 1ns/1ns
module cpu_bus_and_block_move_bench import cpu_pkg::*;;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    sys_mode_t mode_sel = MODE_ACTIVE;
    logic cmd_valid = 1'b0, cmd_word = 1'b0, irq_req = 1'b0;
    cmd_t cmd_op = CMD_NOP;
    bit_op_t cmd_bit_op = BOP_SET;
    gpr_sel_t cmd_gpr = GPR_COUNT;
    logic [2:0] cmd_bit_idx = 3'h0;
    logic [15:0] cmd_addr = 16'h0000, cmd_wdata = 16'h0000, pc_in = 16'h0000;
    logic [7:0] ccr_in = 8'h00, ext_en = 8'h00, ext_lvl = 8'h00;
    logic cmd_ready, cmd_done, irq_ack;
    logic [15:0] rd_data, source_out, dest_out, stack_out;
    core_state_t core_state;
    logic [7:0] count_out, pin_in, pin_out, pin_oe, v;
    int fail_count, cmp_count, lat, lat_act;

    // Short divide keeps subactive runs brief
    cpu_bus_and_block_move #(.SUB_DIV(2)) dut (.core_clk, .rst,
        .mode_sel, .cmd_valid, .cmd_op, .cmd_bit_op, .cmd_bit_idx,
        .cmd_gpr, .cmd_word, .cmd_addr, .cmd_wdata, .pc_in, .ccr_in,
        .irq_req, .pin_in, .cmd_ready, .cmd_done, .irq_ack, .rd_data,
        .core_state, .count_out, .source_out, .dest_out, .stack_out,
        .pin_out, .pin_oe);
    pin_load pins (.pin_out, .pin_oe, .ext_en, .ext_lvl, .pin_in);

    // Free-running clock
    always #5 core_clk = ~core_clk;

    // ====================
    // Shared tasks
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick

    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", s, e, g);
            fail_count++;
        end
    endtask : chk

    // Holds the request until the edge that takes it
    task automatic go(cmd_t op, logic [15:0] a = 16'h0000,
            logic [15:0] d = 16'h0000, logic w = 1'b0, bit_op_t b = BOP_SET,
            logic [2:0] i = 3'h0, gpr_sel_t g = GPR_COUNT);
        while (cmd_ready !== 1'b1) tick();
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_word = w;
        cmd_bit_op = b;
        cmd_bit_idx = i;
        cmd_gpr = g;
        cmd_valid = 1'b1;
        tick();
        cmd_valid = 1'b0;
        for (lat = 1; cmd_done !== 1'b1; lat++) tick();
    endtask : go

    task automatic ld(gpr_sel_t g, logic [15:0] d);
        go(CMD_LOAD_GPR, 16'h0000, d, 1'b0, BOP_SET, 3'h0, g);
    endtask : ld

    // ====================
    // Scenarios
    task automatic t_mem();
        go(CMD_WRITE, 16'h0100, 16'h1234, 1'b1);
        go(CMD_WRITE, 16'h0102, 16'h0077);
        go(CMD_READ, 16'h0100, 16'h0000, 1'b1);
        lat_act = lat;
        chk("mem word", 16'h1234, rd_data);
        go(CMD_READ, 16'h0101);
        chk("mem byte", 16'h0034, 16'(rd_data[7:0]));
        go(CMD_WRITE, 16'hF000, 16'h00AA);
        go(CMD_READ, 16'hF000);
        chk("empty read", 16'h0000, rd_data);
        $display("memory test done");
    endtask : t_mem

    task automatic t_bits();
        logic [7:0] e [5] = '{8'h5E, 8'h5A, 8'h5E, 8'h5A, 8'h5A};
        go(CMD_WRITE, 16'h0200, 16'h0033);
        for (int k = 0; k < 5; k++) begin
            ccr_in = {7'h00, k == 4};
            go(CMD_WRITE, 16'h0201, 16'h005A);
            go(CMD_BIT, 16'h0201, 16'h0000, 1'b0, bit_op_t'(k), 3'h2);
            go(CMD_READ, 16'h0201);
            chk("bit op", 16'(e[k]), 16'(rd_data[7:0]));
        end
        go(CMD_READ, 16'h0200, 16'h0000, 1'b1);
        chk("neighbour byte", 16'h335A, rd_data);
        $display("bit test done");
    endtask : t_bits

    task automatic t_io();
        ext_en = 8'h0F;
        ext_lvl = 8'h06;
        go(CMD_WRITE, PORT_DIR_ADDR);
        go(CMD_WRITE, PORT_DATA_ADDR, 16'hA55A, 1'b1);
        chk("hv enable", 16'h00A0, 16'(pin_oe));
        go(CMD_READ, PORT_DATA_ADDR, 16'h0000, 1'b1);
        chk("port word", 16'hA600, rd_data);
        ext_en = 8'h4F;
        ext_lvl = 8'h46;
        go(CMD_BIT, PORT_DATA_ADDR, 16'h0000, 1'b0, BOP_SET, 3'h4);
        chk("rmw set", 16'h00F0, 16'(pin_oe));
        go(CMD_BIT, PORT_DATA_ADDR, 16'h0000, 1'b0, BOP_CLEAR, 3'h7);
        chk("rmw clear", 16'h0070, 16'(pin_oe));
        chk("pulled low", 16'h0000, 16'(pin_in[7]));
        go(CMD_WRITE, PORT_DIR_ADDR, 16'h000F);
        ext_lvl = 8'h49;
        go(CMD_READ, PORT_DATA_ADDR);
        chk("port latch", 16'h0076, 16'(rd_data[7:0]));
        go(CMD_WRITE, TIMER_ADDR, 16'h0040);
        go(CMD_READ, TIMER_ADDR);
        v = rd_data[7:0];
        go(CMD_READ, TIMER_ADDR);
        chk("timer runs", 16'h0001, 16'(rd_data[7:0] !== v));
        $display("port test done");
    endtask : t_io

    task automatic t_bm();
        go(CMD_WRITE, 16'h0303, 16'h00EE);
        ld(GPR_COUNT, 16'h0003);
        ld(GPR_SOURCE, 16'h0100);
        // Destination plus count stays below the top
        ld(GPR_DEST, 16'h0300);
        go(CMD_BLOCK_MOVE);
        chk("count", 16'h0000, 16'(count_out));
        chk("source", 16'h0103, source_out);
        chk("dest", 16'h0303, dest_out);
        go(CMD_READ, 16'h0300, 16'h0000, 1'b1);
        chk("moved word", 16'h1234, rd_data);
        go(CMD_READ, 16'h0302, 16'h0000, 1'b1);
        chk("moved tail", 16'h77EE, rd_data);
        go(CMD_BLOCK_MOVE);
        chk("zero move", 16'h0103, source_out);
        chk("zero time", 16'h0001, 16'(lat));
        $display("block move test done");
    endtask : t_bm

    task automatic t_irq();
        ld(GPR_STACK, 16'h0400);
        pc_in = 16'hBEEF;
        ccr_in = 8'h81;
        irq_req = 1'b1;
        tick();
        chk("exception", 16'(CS_EXCEPT), 16'(core_state));
        while (irq_ack !== 1'b1) tick();
        irq_req = 1'b0;
        chk("irq ack", 16'h0001, 16'(irq_ack));
        chk("stack", 16'h03FC, stack_out);
        go(CMD_READ, 16'h03FE, 16'h0000, 1'b1);
        chk("saved pc", 16'hBEEF, rd_data);
        go(CMD_READ, 16'h03FC, 16'h0000, 1'b1);
        chk("saved flags", 16'h8181, rd_data);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_modes();
        mode_sel = MODE_SUBACTIVE;
        go(CMD_READ, 16'h0100, 16'h0000, 1'b1);
        chk("sub data", 16'h1234, rd_data);
        chk("sub slower", 16'h0001, 16'(lat > lat_act));
        for (int k = 2; k < 5; k++) begin
            mode_sel = sys_mode_t'(k);
            repeat (3) tick();
            chk("halt ready", 16'h0000, 16'(cmd_ready));
        end
        mode_sel = MODE_ACTIVE;
        $display("mode test done");
    endtask : t_modes

    // ====================
    // Verdict, sequence and watchdog
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20) tick();
        rst = 1'b0;
        t_mem();
        t_bits();
        t_io();
        t_bm();
        t_irq();
        t_modes();
        conclude();
    end

    // Over a hundred times the expected run means a hang
    initial begin
        #300000;
        fail_count++;
        conclude();
    end
endmodule : cpu_bus_and_block_move_bench

// ### tb/cpu_checks_asserts.sv
// Port-level assertion checker for the bus and block-move core
`timescale 1ns/1ns
module cpu_checks import cpu_pkg::*; #(
    parameter logic [7:0] HV_MASK = HV_MASK_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire sys_mode_t mode_sel,
    input wire logic cmd_valid,
    input wire cmd_t cmd_op,
    input wire logic irq_req,
    input wire logic cmd_ready,
    input wire logic cmd_done,
    input wire logic irq_ack,
    input wire core_state_t core_state,
    input wire logic [7:0] count_out,
    input wire logic [15:0] source_out,
    input wire logic [7:0] pin_out
);
    // ====================
    // Command sequences
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence take_s; cmd_valid && cmd_ready; endsequence
    sequence rw_s;
        take_s ##0 cmd_op inside {CMD_READ, CMD_WRITE} ##0
            mode_sel == MODE_ACTIVE;
    endsequence
    sequence bm_s; take_s ##0 cmd_op == CMD_BLOCK_MOVE; endsequence
    // ====================
    // Assertions
    rw_time_a: assert property (rw_s |=> !cmd_done [*2] ##[1:2] cmd_done)
        else $error("bus cycle length wrong");
    rw_busy_a: assert property (rw_s |=> !cmd_ready [*2])
        else $error("ready during bus cycle");
    load_a: assert property (take_s ##0 cmd_op == CMD_LOAD_GPR |=> cmd_done)
        else $error("load not done");
    bm_end_a: assert property (bm_s |=> (!cmd_done until
        (cmd_done && count_out == 8'h00))) else $error("move ends early");
    bm_bound_a: assert property (bm_s |-> ##[1:1000] cmd_done)
        else $error("move never ends");
    zero_move_a: assert property (bm_s ##0 count_out == 8'h00 |=>
        cmd_done && $stable(source_out)) else $error("zero move");
    ready_back_a: assert property (cmd_done && !$past(irq_req) &&
        $past(mode_sel) == MODE_ACTIVE |-> cmd_ready)
        else $error("ready late after done");
    halt_a: assert property ((mode_sel inside {MODE_SLEEP, MODE_STANDBY,
        MODE_WATCH}) [*2] |-> !cmd_ready) else $error("ready in halt");
    irq_hold_a: assert property (irq_req |=> !cmd_ready)
        else $error("ready with interrupt");
    exc_ack_a: assert property ($rose(core_state == CS_EXCEPT) |->
        ##[1:40] irq_ack) else $error("no interrupt ack");
    hv_high_a: assert property (!$past(rst) |->
        (pin_out & HV_MASK) == HV_MASK) else $error("hv level low");
endmodule : cpu_checks

bind cpu_bus_and_block_move cpu_checks #(.HV_MASK(HV_MASK)) chk_i (
    .core_clk, .rst, .mode_sel, .cmd_valid, .cmd_op, .irq_req,
    .cmd_ready, .cmd_done, .irq_ack, .core_state, .count_out,
    .source_out, .pin_out
);

// ### tb/pin_load.sv
// Port pin load model: driven, forced and pulled-down levels
`timescale 1ns/1ns
module pin_load (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_lvl,
    output logic [7:0] pin_in
);
    // ====================
    // Pin resolution
    // Released pins not forced by ext_en fall to the pull-down
    assign pin_in = (pin_oe & pin_out) |
        (~pin_oe & ext_en & ext_lvl);
endmodule : pin_load
